//--- core/text_capture_pkg.sv
package text_capture_pkg;
	localparam int char_bits = 8;
	localparam logic [7:0] line_terminator_char = 8'h0d;
	localparam logic [7:0] escape_char = 8'h1b;
	localparam logic [7:0] halt_char = 8'h04;
	localparam logic [7:0] shield_enable_char = 8'h0f;
	localparam int line_depth = 128;
	localparam int line_index_bits = 8;
	localparam logic [7:0] reset_char = 8'h00;
	localparam logic [2:0] bit_count_last = 3'h7;
	// number of cycles the end-of-simulation pulse is held
	localparam int sim_end_cycles = 1;
endpackage : text_capture_pkg

//--- core/serial_deserialiser.sv
`timescale 1ns/1ps
// one bit per clock, no oversampling: start bit, eight data lsb first, stop
module serial_deserialiser (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic serial_in,
	output logic [7:0] char_out,
	output logic char_valid_out,
	output logic frame_error_out
);
	typedef enum logic [1:0] {idle_s, data_s, stop_s} rx_state_t;
	rx_state_t state_ff;
	logic [7:0] shift_ff;
	logic [2:0] count_ff;

	wire start_seen = (state_ff == idle_s) && !serial_in;
	wire last_data = (state_ff == data_s) && (count_ff == text_capture_pkg::bit_count_last);

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_ff <= idle_s;
			shift_ff <= text_capture_pkg::reset_char;
			count_ff <= 3'h0;
			char_out <= text_capture_pkg::reset_char;
			char_valid_out <= 1'b0;
			frame_error_out <= 1'b0;
		end else begin
			char_valid_out <= 1'b0;
			frame_error_out <= 1'b0;
			unique case (state_ff)
				idle_s: begin
					count_ff <= 3'h0;
					if (start_seen) begin
						state_ff <= data_s;
					end
				end
				data_s: begin
					shift_ff <= {serial_in, shift_ff[7:1]};
					count_ff <= count_ff + 3'h1;
					if (last_data) begin
						state_ff <= stop_s;
					end
				end
				stop_s: begin
					state_ff <= idle_s;
					// a low stop bit drops the character rather than guessing
					if (serial_in) begin
						char_out <= shift_ff;
						char_valid_out <= 1'b1;
					end else begin
						frame_error_out <= 1'b1;
					end
				end
			endcase
		end
	end

	chk_start_to_valid: assert property (@(posedge clk_in) disable iff (reset_in)
		start_seen ##1 (state_ff == data_s) [*8] ##1 serial_in |=> char_valid_out)
		else $error("character not delivered ten cycles after start");
	chk_valid_after_stop: assert property (@(posedge clk_in) disable iff (reset_in)
		char_valid_out |-> $past(state_ff == stop_s) && $past(serial_in))
		else $error("character delivered without a high stop bit");
	chk_data_bit_order: assert property (@(posedge clk_in) disable iff (reset_in)
		(state_ff == data_s) && (count_ff == 3'h0) |=> shift_ff[7] == $past(serial_in))
		else $error("first data bit not shifted into msb end");
	cov_char: cover property (@(posedge clk_in) char_valid_out);
	cov_ferr: cover property (@(posedge clk_in) frame_error_out);
endmodule : serial_deserialiser

//--- core/uart_text_capture_monitor.sv
`timescale 1ns/1ps
module uart_text_capture_monitor #(
	parameter int line_depth = text_capture_pkg::line_depth
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic primary_console_uart_in,
	output logic [7:0] line_char_out,
	output logic line_char_valid_out,
	output logic line_done_out,
	output logic sim_end_pulse_out,
	output logic halted_out,
	output logic shields_enable_out,
	output logic frame_error_out
);
	////////////////////////////////////////////////////////////////////////
	logic [7:0] rx_char;
	logic rx_valid;
	logic rx_ferr;
	logic [7:0] line_mem [line_depth];
	logic [7:0] wr_count_ff;
	logic [7:0] rd_index_ff;
	logic [7:0] emit_len_ff;
	logic emitting_ff;
	logic prev_escape_ff;
	logic halt_pending_ff;
	logic [7:0] emitted_count_ff;
	logic [7:0] first_char_ff;
	// the slot index follows the buffer depth; the 8-bit counters keep a spare bit so that full differs from empty for depths up to 128
	localparam int slot_bits = $clog2(line_depth);
	wire [slot_bits-1:0] wr_slot = wr_count_ff[slot_bits-1:0];
	wire [slot_bits-1:0] rd_slot = rd_index_ff[slot_bits-1:0];

	// the transmitter pacing one bit per clock is assumed, not checked
	serial_deserialiser serial_deserialiser_i (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.serial_in(primary_console_uart_in),
		.char_out(rx_char),
		.char_valid_out(rx_valid),
		.frame_error_out(rx_ferr)
	);

	////////////////////////////////////////////////////////////////////////
	// one comparison shared by every control-character decode
	function automatic logic char_matches(input logic [7:0] c, input logic [7:0] code);
		return c == code;
	endfunction : char_matches

	wire is_term = rx_valid && char_matches(rx_char, text_capture_pkg::line_terminator_char);
	wire is_halt = rx_valid && char_matches(rx_char, text_capture_pkg::halt_char) && !prev_escape_ff;
	wire is_shield = rx_valid && char_matches(rx_char, text_capture_pkg::shield_enable_char);
	wire line_full = wr_count_ff == 8'(line_depth);
	wire store_char = rx_valid && !is_term && !line_full;
	wire start_emit = is_term && !emitting_ff;
	wire emit_last = emitting_ff && (rd_index_ff == emit_len_ff);
	// a line that arrives while the previous one is still draining is dropped:
	// one buffer keeps area small, and lines are far apart at ten cycles per char
	wire [7:0] nxt_wr_count = start_emit ? 8'h00 : (store_char ? wr_count_ff + 8'h01 : wr_count_ff);

	always_ff @(posedge clk_in) begin
		if (store_char && !emitting_ff) begin
			line_mem[wr_slot] <= rx_char;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			wr_count_ff <= 8'h00;
			rd_index_ff <= 8'h00;
			emit_len_ff <= 8'h00;
			emitting_ff <= 1'b0;
			line_char_out <= 8'h00;
			line_char_valid_out <= 1'b0;
			line_done_out <= 1'b0;
		end else begin
			line_char_valid_out <= 1'b0;
			line_done_out <= 1'b0;
			if (!emitting_ff) begin
				wr_count_ff <= nxt_wr_count;
			end
			if (start_emit) begin
				emitting_ff <= 1'b1;
				emit_len_ff <= wr_count_ff;
				rd_index_ff <= 8'h00;
			end else if (emit_last) begin
				emitting_ff <= 1'b0;
				line_done_out <= 1'b1;
			end else if (emitting_ff) begin
				line_char_out <= line_mem[rd_slot];
				line_char_valid_out <= 1'b1;
				rd_index_ff <= rd_index_ff + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			prev_escape_ff <= 1'b0;
			halt_pending_ff <= 1'b0;
			sim_end_pulse_out <= 1'b0;
			halted_out <= 1'b0;
			shields_enable_out <= 1'b0;
			frame_error_out <= 1'b0;
		end else begin
			frame_error_out <= rx_ferr;
			if (rx_valid) begin
				prev_escape_ff <= char_matches(rx_char, text_capture_pkg::escape_char);
			end
			sim_end_pulse_out <= is_halt && !halted_out;
			halt_pending_ff <= is_halt && !halted_out;
			// halt follows the pulse by one cycle so listeners see it first
			if (halt_pending_ff) begin
				halted_out <= 1'b1;
			end
			if (is_shield) begin
				shields_enable_out <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checking aids only: characters put out since the last line end, and the first one stored
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			emitted_count_ff <= 8'h00;
		end else if (line_done_out) begin
			emitted_count_ff <= 8'h00;
		end else if (line_char_valid_out) begin
			emitted_count_ff <= emitted_count_ff + 8'h01;
		end
	end

	always_ff @(posedge clk_in) begin
		if (store_char && !emitting_ff && (wr_count_ff == 8'h00)) begin
			first_char_ff <= rx_char;
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_halt_pulse_first: assert property (@(posedge clk_in) disable iff (reset_in)
		$rose(halted_out) |-> $past(sim_end_pulse_out))
		else $error("halt without preceding end pulse");
	chk_halt_char_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
		is_halt && !halted_out |=> sim_end_pulse_out ##1 halted_out)
		else $error("halt character did not end the run");
	chk_escape_blocks_halt: assert property (@(posedge clk_in) disable iff (reset_in)
		rx_valid && prev_escape_ff && rx_char == text_capture_pkg::halt_char |=> !sim_end_pulse_out)
		else $error("escaped halt character ended the run");
	chk_pulse_one_cycle: assert property (@(posedge clk_in) disable iff (reset_in)
		sim_end_pulse_out |=> !sim_end_pulse_out)
		else $error("end pulse longer than one cycle");
	chk_shield_enable: assert property (@(posedge clk_in) disable iff (reset_in)
		is_shield |=> shields_enable_out)
		else $error("shield enable character ignored");
	chk_line_ends: assert property (@(posedge clk_in) disable iff (reset_in)
		start_emit |-> ##[1:130] line_done_out)
		else $error("line not emitted after terminator");
	chk_line_count: assert property (@(posedge clk_in) disable iff (reset_in)
		start_emit && wr_count_ff == 8'h02 |=> ##1 line_char_valid_out ##1 line_char_valid_out ##1 line_done_out)
		else $error("two character line not emitted as two characters");
	chk_sample_per_bit: assert property (@(posedge clk_in) disable iff (reset_in)
		rx_valid |=> !rx_valid [*8])
		else $error("characters closer than one bit per cycle allows");
	// invariants of the line buffer, the escape memory, the frame error output and the sticky control outputs
	chk_halt_only_once: assert property (@(posedge clk_in) disable iff (reset_in)
		halted_out |-> !sim_end_pulse_out)
		else $error("end pulse repeated after the halt");
	chk_halt_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
		halted_out |=> halted_out)
		else $error("halt released without reset");
	chk_pulse_needs_char: assert property (@(posedge clk_in) disable iff (reset_in)
		sim_end_pulse_out |-> $past(is_halt))
		else $error("end pulse without an unescaped halt character");
	chk_escape_forgotten: assert property (@(posedge clk_in) disable iff (reset_in)
		rx_valid && !char_matches(rx_char, text_capture_pkg::escape_char) |=> !prev_escape_ff)
		else $error("escape remembered past the next character");
	chk_shield_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
		shields_enable_out |=> shields_enable_out)
		else $error("shield enable dropped without reset");
	chk_shield_needs_char: assert property (@(posedge clk_in) disable iff (reset_in)
		$rose(shields_enable_out) |-> $past(is_shield))
		else $error("shield enable without its character");
	chk_ferr_forwarded: assert property (@(posedge clk_in) disable iff (reset_in)
		rx_ferr |=> frame_error_out)
		else $error("bad stop bit not reported");
	chk_ferr_needs_cause: assert property (@(posedge clk_in) disable iff (reset_in)
		frame_error_out |-> $past(rx_ferr))
		else $error("frame error reported without a bad stop bit");
	chk_terminator_kept_back: assert property (@(posedge clk_in) disable iff (reset_in)
		line_char_valid_out |-> line_char_out != text_capture_pkg::line_terminator_char)
		else $error("terminator emitted as part of a line");
	chk_all_chars_out: assert property (@(posedge clk_in) disable iff (reset_in)
		line_done_out |-> emitted_count_ff == emit_len_ff)
		else $error("line ended before all its characters were emitted");
	chk_first_char_order: assert property (@(posedge clk_in) disable iff (reset_in)
		line_char_valid_out && (emitted_count_ff == 8'h00) |-> line_char_out == first_char_ff)
		else $error("line did not start with its first received character");
	chk_line_bounded: assert property (@(posedge clk_in) disable iff (reset_in)
		wr_count_ff <= 8'(line_depth))
		else $error("line buffer count beyond its depth");
	chk_done_alone: assert property (@(posedge clk_in) disable iff (reset_in)
		line_done_out |-> !line_char_valid_out)
		else $error("line end overlaps a character");
	chk_drain_drops_input: assert property (@(posedge clk_in) disable iff (reset_in)
		emitting_ff |-> wr_count_ff == 8'h00)
		else $error("characters stored while a line drains");
	chk_emit_len_bounded: assert property (@(posedge clk_in) disable iff (reset_in)
		emitting_ff |-> emit_len_ff <= 8'(line_depth))
		else $error("line length beyond buffer depth");
	cov_line: cover property (@(posedge clk_in) line_done_out);
	cov_halt: cover property (@(posedge clk_in) sim_end_pulse_out);
	cov_shield: cover property (@(posedge clk_in) $rose(shields_enable_out));
endmodule : uart_text_capture_monitor

//--- sim/console_sender.sv
`timescale 1ns/1ps
// behavioural transmitter in fast test mode: one bit per clock
module console_sender (
	input wire logic clk_in,
	output logic line_out
);
	initial line_out = 1'b1;
	// bits change at the edge, so the monitor takes each one a clock later
	task automatic send(input logic [7:0] c, input logic stop_ok);
		@(posedge clk_in) line_out <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_in) line_out <= c[i];
		end
		@(posedge clk_in) line_out <= stop_ok;
		if (!stop_ok) begin
			@(posedge clk_in) line_out <= 1'b1;
		end
	endtask : send
endmodule : console_sender

//--- sim/tb_uart_text_capture_monitor.sv
`timescale 1ns/1ps
module tb_uart_text_capture_monitor;
	logic clk_in = 1'b0;
	logic reset_in;
	logic serial_line;
	logic [7:0] line_char_out;
	logic line_char_valid_out, line_done_out, sim_end_pulse_out;
	logic halted_out, shields_enable_out, frame_error_out;
	logic halt_at_pulse = 1'b1;
	logic [7:0] got_q[$];
	int n_errors = 0, n_checks = 0, n_lines = 0, n_ends = 0, n_frames = 0, n_cycles = 0;
	////////////////////////////////////////////////////////////////
	console_sender console_sender_i (.clk_in(clk_in), .line_out(serial_line));
	uart_text_capture_monitor uart_text_capture_monitor_i (.clk_in(clk_in), .reset_in(reset_in),
		.primary_console_uart_in(serial_line), .line_char_out(line_char_out),
		.line_char_valid_out(line_char_valid_out), .line_done_out(line_done_out),
		.sim_end_pulse_out(sim_end_pulse_out), .halted_out(halted_out),
		.shields_enable_out(shields_enable_out), .frame_error_out(frame_error_out));
	initial begin
		forever #25 clk_in = ~clk_in;
	end
	// outputs are registered, so values read here are those of the cycle just ended
	always @(posedge clk_in) begin
		if (line_char_valid_out === 1'b1) got_q.push_back(line_char_out);
		if (line_done_out === 1'b1) n_lines++;
		if (frame_error_out === 1'b1) n_frames++;
		if (sim_end_pulse_out === 1'b1) begin
			n_ends++;
			halt_at_pulse = halted_out;
		end
		n_cycles++;
		if (n_cycles == 3000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wait_lines(input int l0);
		for (int i = 0; i < 60 && n_lines == l0; i++) @(posedge clk_in);
	endtask : wait_lines
	task automatic test_line();
		int l0;
		l0 = n_lines;
		got_q.delete();
		console_sender_i.send(8'h48, 1'b1);
		console_sender_i.send(8'h69, 1'b1);
		console_sender_i.send(text_capture_pkg::line_terminator_char, 1'b1);
		wait_lines(l0);
		check(8'(n_lines - l0), 8'h01);
		check(8'(got_q.size()), 8'h02);
		check(got_q[0], 8'h48);
		check(got_q[1], 8'h69);
		$display("test_line done");
	endtask : test_line
	task automatic test_frame();
		int l0;
		l0 = n_lines;
		got_q.delete();
		console_sender_i.send(8'h41, 1'b0);
		console_sender_i.send(text_capture_pkg::line_terminator_char, 1'b1);
		wait_lines(l0);
		check(8'(n_frames), 8'h01);
		check(8'(got_q.size()), 8'h00);
		check(8'(n_lines - l0), 8'h01);
		$display("test_frame done");
	endtask : test_frame
	task automatic test_shields();
		check({7'h00, shields_enable_out}, 8'h00);
		console_sender_i.send(text_capture_pkg::shield_enable_char, 1'b1);
		repeat (4) @(posedge clk_in);
		check({7'h00, shields_enable_out}, 8'h01);
		$display("test_shields done");
	endtask : test_shields
	task automatic test_halt();
		console_sender_i.send(text_capture_pkg::escape_char, 1'b1);
		console_sender_i.send(text_capture_pkg::halt_char, 1'b1);
		repeat (4) @(posedge clk_in);
		check(8'(n_ends), 8'h00);
		check({7'h00, halted_out}, 8'h00);
		console_sender_i.send(text_capture_pkg::halt_char, 1'b1);
		repeat (4) @(posedge clk_in);
		check(8'(n_ends), 8'h01);
		check({7'h00, halt_at_pulse}, 8'h00);
		check({7'h00, halted_out}, 8'h01);
		$display("test_halt done");
	endtask : test_halt
	task automatic test_reset();
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		check({7'h00, halted_out}, 8'h00);
		check({7'h00, shields_enable_out}, 8'h00);
		$display("test_reset done");
	endtask : test_reset
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////
	initial begin
		reset_in = 1'b1;
		repeat (5) @(posedge clk_in);
		reset_in <= 1'b0;
		test_line();
		test_frame();
		test_shields();
		test_halt();
		test_reset();
		test_line();
		tally_and_finish();
	end
endmodule : tb_uart_text_capture_monitor
